// file: hdl/port_containment.sv
// Containment trigger, status and signalling for one downstream port.
// Assumes error pulses and the APB master run on the core clock.
//
// Behaviour
// - Trigger enable 00b (reset) or reserved 11b keeps containment off.
// - Enable 01b triggers on a local uncorrectable error or ERR_FATAL.
// - Enable 10b also triggers on a received ERR_NONFATAL.
// - Contained completions carry CA when bit 18 is 0, UR when 1.
// - Bit 19 set makes a trigger raise the containment interrupt.
// - Bit 20 set makes a trigger send one ERR_COR message request.
// - Status bit 0 sets on trigger and clears only by writing one.
// - Reason bits 2:1 record 00b local, 01b nonfatal, 10b fatal.
// - Status bit 3 sets only on a trigger with interrupts enabled.
// - The read-only vector field at bits 4:0 resets to 00001b.
// - Bits 31:16 of status hold the requester ID of the message.
//
// Design decision made here: the APB slave port.
module port_containment (
	input  wire logic                      clock,
	input  wire logic                      sys_rst,
	input  wire logic [11:0]               paddr,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  containment_pkg::err_in_s       err_in,
	output logic                           contained,
	output logic      [2:0]                cpl_status,
	output logic                           msi_req,
	output logic      [4:0]                msi_vector,
	output logic                           err_cor_req,
	output logic                           irq
);

	typedef enum logic [1:0] {
		ST_IDLE      = 2'b01,
		ST_CONTAINED = 2'b10
	} state_e;

	state_e                     state, next_state;
	containment_pkg::trig_en_e  trig_en, next_trig_en;
	logic                       cpl_ctl, next_cpl_ctl;
	logic                       int_en, next_int_en;
	logic                       errcor_en, next_errcor_en;
	containment_pkg::reason_e   reason, next_reason;
	logic                       int_st, next_int_st;
	logic [15:0]                src_id, next_src_id;
	logic [3:0]                 evt_mask, next_evt_mask;
	logic [3:0]                 evt;
	logic [3:0]                 evt_set;
	logic [3:0]                 evt_clr;
	logic                       fire_raw;
	logic                       fire;
	containment_pkg::reason_e   fire_reason;
	logic [31:0]                next_prdata;
	logic                       next_pready, next_pslverr;
	logic                       next_msi_req;
	logic                       next_err_cor_req;
	logic                       next_irq;
	logic [2:0]                 next_cpl_status;
	logic                       wr_acc, w1c_trig;

	// Address decode shared by read and write paths
	function automatic logic mapped(input logic [11:0] a);
		return (a == containment_pkg::OFS_CAP_CTRL) ||
			(a == containment_pkg::OFS_STATUS) ||
			(a == containment_pkg::OFS_EVT) ||
			(a == containment_pkg::OFS_MASK);
	endfunction : mapped

	// Qualification of the raw error inputs
	trigger_detect detect (
		.mode   (trig_en),
		.err    (err_in),
		.fire   (fire_raw),
		.reason (fire_reason)
	);

	// A second trigger while contained is ignored so captures hold
	assign fire     = fire_raw && (state == ST_IDLE);
	assign wr_acc   = psel && penable && pready && pwrite;
	assign w1c_trig = wr_acc && (paddr == containment_pkg::OFS_STATUS) &&
		pwdata[containment_pkg::ST_TRIG_BIT];

	// Event bits: trigger, local error, nonfatal and fatal messages
	assign evt_set = {err_in.fatal, err_in.nonfatal, err_in.uncor, fire};
	assign evt_clr = (wr_acc && paddr == containment_pkg::OFS_EVT) ?
		pwdata[3:0] : 4'h0;

	sticky_w1c #(
		.W (containment_pkg::EVT_W)
	) events (
		.clock   (clock),
		.sys_rst (sys_rst),
		.set     (evt_set),
		.clr     (evt_clr),
		.q       (evt)
	);

	// Containment state and its captured cause
	always_comb
	begin
		next_state  = state;
		next_reason = reason;
		next_src_id = src_id;
		next_int_st = int_st;
		if (wr_acc && paddr == containment_pkg::OFS_STATUS)
		begin
			if (pwdata[containment_pkg::ST_TRIG_BIT])
				next_state = ST_IDLE;
			next_reason = containment_pkg::reason_e'(reason &
				~pwdata[containment_pkg::REASON_LSB +: 2]);
			if (pwdata[containment_pkg::ST_INT_BIT])
				next_int_st = 1'h0;
		end
		// Setting beats a clear landing in the same cycle
		if (fire)
		begin
			next_state  = ST_CONTAINED;
			next_reason = fire_reason;
			if (fire_reason != containment_pkg::RSN_UNCOR)
				next_src_id = err_in.req_id;
			if (int_en)
				next_int_st = 1'h1;
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			state  <= ST_IDLE;
			reason <= containment_pkg::RSN_UNCOR;
			src_id <= containment_pkg::SRC_ID_RST;
			int_st <= 1'h0;
		end
		else
		begin
			state  <= next_state;
			reason <= next_reason;
			src_id <= next_src_id;
			int_st <= next_int_st;
		end
	end

	// Control and mask registers written by software
	always_comb
	begin
		next_trig_en   = trig_en;
		next_cpl_ctl   = cpl_ctl;
		next_int_en    = int_en;
		next_errcor_en = errcor_en;
		next_evt_mask  = evt_mask;
		if (wr_acc && paddr == containment_pkg::OFS_CAP_CTRL)
		begin
			// Reserved 11b is stored but acts as disabled
			next_trig_en   = containment_pkg::trig_en_e'(
				pwdata[containment_pkg::TRIG_EN_LSB +: 2]);
			next_cpl_ctl   = pwdata[containment_pkg::CPL_CTRL_BIT];
			next_int_en    = pwdata[containment_pkg::INT_EN_BIT];
			next_errcor_en = pwdata[containment_pkg::ERRCOR_EN_BIT];
		end
		if (wr_acc && paddr == containment_pkg::OFS_MASK)
			next_evt_mask = pwdata[3:0];
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			trig_en   <= containment_pkg::TRIG_OFF;
			cpl_ctl   <= 1'h0;
			int_en    <= 1'h0;
			errcor_en <= 1'h0;
			evt_mask  <= 4'h0;
		end
		else
		begin
			trig_en   <= next_trig_en;
			cpl_ctl   <= next_cpl_ctl;
			int_en    <= next_int_en;
			errcor_en <= next_errcor_en;
			evt_mask  <= next_evt_mask;
		end
	end

	// APB slave: data is fetched in setup, so every access has no wait
	always_comb
	begin
		next_pready  = psel && !penable;
		next_pslverr = psel && !penable && !mapped(paddr);
		next_prdata  = 32'h0000_0000;
		if (psel && !penable && !pwrite)
		begin
			case (paddr)
				containment_pkg::OFS_CAP_CTRL:
				begin
					next_prdata[containment_pkg::MSG_NUM_LSB +: 5] =
						containment_pkg::MSG_NUM_RST;
					next_prdata[containment_pkg::TRIG_EN_LSB +: 2] = trig_en;
					next_prdata[containment_pkg::CPL_CTRL_BIT]   = cpl_ctl;
					next_prdata[containment_pkg::INT_EN_BIT]     = int_en;
					next_prdata[containment_pkg::ERRCOR_EN_BIT]  = errcor_en;
				end
				containment_pkg::OFS_STATUS:
				begin
					next_prdata[containment_pkg::ST_TRIG_BIT] =
						(state == ST_CONTAINED);
					next_prdata[containment_pkg::REASON_LSB +: 2] = reason;
					next_prdata[containment_pkg::ST_INT_BIT] = int_st;
					next_prdata[containment_pkg::SRC_ID_LSB +: 16] =
						src_id;
				end
				containment_pkg::OFS_EVT:  next_prdata[3:0] = evt;
				containment_pkg::OFS_MASK: next_prdata[3:0] = evt_mask;
				default: next_prdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'h0;
			pslverr <= 1'h0;
		end
		else
		begin
			prdata  <= next_prdata;
			pready  <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// Port-side outputs, all registered
	always_comb
	begin
		next_msi_req     = fire && int_en;
		next_err_cor_req = fire && errcor_en;
		next_irq         = |(next_evt_mask & ((evt & ~evt_clr) | evt_set));
		next_cpl_status  = cpl_ctl ? containment_pkg::CPL_UR :
			containment_pkg::CPL_CA;
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			msi_req     <= 1'h0;
			err_cor_req <= 1'h0;
			irq         <= 1'h0;
			cpl_status  <= containment_pkg::CPL_CA;
			msi_vector  <= containment_pkg::MSG_NUM_RST;
			contained   <= 1'h0;
		end
		else
		begin
			msi_req     <= next_msi_req;
			err_cor_req <= next_err_cor_req;
			irq         <= next_irq;
			cpl_status  <= next_cpl_status;
			msi_vector  <= containment_pkg::MSG_NUM_RST;
			contained   <= (next_state == ST_CONTAINED);
		end
	end

	// Checks on the behaviour above
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	sequence s_idle_error;
		state == ST_IDLE && (err_in.uncor || err_in.fatal);
	endsequence

	sequence s_no_clear;
		!w1c_trig;
	endsequence

	property p_off_quiet;
		(trig_en == containment_pkg::TRIG_OFF ||
			trig_en == containment_pkg::TRIG_RSVD) && state == ST_IDLE
			|=> state == ST_IDLE;
	endproperty
	a_off_quiet: assert property (p_off_quiet)
		else $error("containment entered while disabled");

	property p_fatal_mode;
		s_idle_error and trig_en == containment_pkg::TRIG_FATAL
			|=> state == ST_CONTAINED && contained;
	endproperty
	a_fatal_mode: assert property (p_fatal_mode)
		else $error("fatal-mode trigger missed");

	property p_fatal_mode_nf;
		state == ST_IDLE && trig_en == containment_pkg::TRIG_FATAL &&
			err_in.nonfatal && !err_in.uncor && !err_in.fatal
			|=> state == ST_IDLE;
	endproperty
	a_fatal_mode_nf: assert property (p_fatal_mode_nf)
		else $error("nonfatal triggered in fatal-only mode");

	property p_any_mode;
		state == ST_IDLE && trig_en == containment_pkg::TRIG_ANY &&
			err_in.nonfatal && !err_in.fatal
			|=> state == ST_CONTAINED &&
			reason == containment_pkg::RSN_NONFATAL;
	endproperty
	a_any_mode: assert property (p_any_mode)
		else $error("nonfatal trigger missed");

	property p_cpl_status;
		cpl_ctl && $past(cpl_ctl) |-> cpl_status == containment_pkg::CPL_UR;
	endproperty
	a_cpl_status: assert property (p_cpl_status)
		else $error("completion status not UR");

	property p_msi;
		fire |=> msi_req == $past(int_en);
	endproperty
	a_msi: assert property (p_msi)
		else $error("interrupt request wrong on trigger");

	property p_err_cor;
		err_cor_req |-> $past(fire) && $past(errcor_en);
	endproperty
	a_err_cor: assert property (p_err_cor)
		else $error("ERR_COR request without enabled trigger");

	property p_hold;
		state == ST_CONTAINED ##0 s_no_clear |=> state == ST_CONTAINED;
	endproperty
	a_hold: assert property (p_hold)
		else $error("trigger status dropped without clear");

	property p_reason_fatal;
		fire && err_in.fatal |=> reason == containment_pkg::RSN_FATAL;
	endproperty
	a_reason_fatal: assert property (p_reason_fatal)
		else $error("fatal reason not recorded");

	property p_int_st;
		$rose(int_st) |-> $past(fire) && $past(int_en);
	endproperty
	a_int_st: assert property (p_int_st)
		else $error("interrupt status set without cause");

	property p_vector;
		psel && penable && pready && !pwrite &&
			paddr == containment_pkg::OFS_CAP_CTRL
			|-> prdata[4:0] == containment_pkg::MSG_NUM_RST;
	endproperty
	a_vector: assert property (p_vector)
		else $error("vector number field wrong");

	property p_src_id;
		fire && err_in.fatal |=> src_id == $past(err_in.req_id);
	endproperty
	a_src_id: assert property (p_src_id)
		else $error("source ID not captured");

	property p_capture_hold;
		state == ST_CONTAINED && !wr_acc |=> $stable(src_id) &&
			$stable(reason);
	endproperty
	a_capture_hold: assert property (p_capture_hold)
		else $error("capture changed while contained");

endmodule : port_containment

// file: hdl/containment_pkg.sv
// Shared constants and types for the port containment block.
// Assumes one core clock and an APB master with 12-bit byte addresses.
package containment_pkg;

	// Register byte offsets
	localparam logic [11:0] OFS_CAP_CTRL = 12'h254;
	localparam logic [11:0] OFS_STATUS   = 12'h258;
	localparam logic [11:0] OFS_EVT      = 12'h25C;
	localparam logic [11:0] OFS_MASK     = 12'h260;

	// Field positions
	localparam int MSG_NUM_LSB   = 0;
	localparam int TRIG_EN_LSB   = 16;
	localparam int CPL_CTRL_BIT  = 18;
	localparam int INT_EN_BIT    = 19;
	localparam int ERRCOR_EN_BIT = 20;
	localparam int ST_TRIG_BIT   = 0;
	localparam int REASON_LSB    = 1;
	localparam int ST_INT_BIT    = 3;
	localparam int SRC_ID_LSB    = 16;
	localparam int EVT_W         = 4;

	// Reset values
	localparam logic [4:0]  MSG_NUM_RST = 5'h01;
	localparam logic [15:0] SRC_ID_RST  = 16'h0000;

	// Completion status codes for completions formed while contained
	localparam logic [2:0] CPL_CA = 3'h4;
	localparam logic [2:0] CPL_UR = 3'h1;

	typedef enum logic [1:0] {
		TRIG_OFF   = 2'h0,
		TRIG_FATAL = 2'h1,
		TRIG_ANY   = 2'h2,
		TRIG_RSVD  = 2'h3
	} trig_en_e;

	typedef enum logic [1:0] {
		RSN_UNCOR    = 2'h0,
		RSN_NONFATAL = 2'h1,
		RSN_FATAL    = 2'h2,
		RSN_RSVD     = 2'h3
	} reason_e;

	// Error inputs from the port, one-cycle pulses on the core clock
	typedef struct packed {
		logic        uncor;
		logic        nonfatal;
		logic        fatal;
		logic [15:0] req_id;
	} err_in_s;

endpackage : containment_pkg

// file: hdl/sticky_w1c.sv
// Write-one-to-clear sticky bits where a set beats a clear.
// Assumes set and clr come from logic on the same clock.
module sticky_w1c #(
	parameter int W = 4
) (
	input  wire logic         clock,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] set,
	input  wire logic [W-1:0] clr,
	output logic      [W-1:0] q
);

	logic [W-1:0] next_q;

	// A set in the clearing cycle is kept, so no event is lost
	always_comb
	begin
		next_q = (q & ~clr) | set;
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
			q <= '0;
		else
			q <= next_q;
	end

endmodule : sticky_w1c

// file: hdl/trigger_detect.sv
// Decides whether the current error inputs qualify as a trigger.
// Assumes the caller gates the result with its own idle state.
module trigger_detect (
	input  containment_pkg::trig_en_e mode,
	input  containment_pkg::err_in_s  err,
	output logic                      fire,
	output containment_pkg::reason_e  reason
);

	// Message kinds that count under a given trigger mode
	function automatic logic counts_nonfatal(
		input containment_pkg::trig_en_e m
	);
		return m == containment_pkg::TRIG_ANY;
	endfunction : counts_nonfatal

	function automatic logic armed(input containment_pkg::trig_en_e m);
		return (m == containment_pkg::TRIG_FATAL) ||
			counts_nonfatal(m);
	endfunction : armed

	// Fatal wins over nonfatal, nonfatal over a local error
	always_comb
	begin
		fire   = armed(mode) && (err.uncor || err.fatal ||
			(err.nonfatal && counts_nonfatal(mode)));
		reason = containment_pkg::RSN_UNCOR;
		if (err.fatal)
			reason = containment_pkg::RSN_FATAL;
		else if (err.nonfatal && counts_nonfatal(mode))
			reason = containment_pkg::RSN_NONFATAL;
	end

endmodule : trigger_detect

// file: sim/link_partner.sv
// Far-side model: link partner error messages and local error detection.
// Assumes send is called just after a rising edge of clock.
module link_partner (
	input  wire logic                clock,
	output containment_pkg::err_in_s err_in
);
	timeunit 1ns;
	timeprecision 1ps;

	initial err_in = '0;

	// One-cycle flag pulse; the ID is inverted once released so that a
	// design reading it outside the pulse sees wrong data
	task send(input logic [2:0] kind, input logic [15:0] id);
	begin
		err_in <= {kind, id};
		@(posedge clock);
		err_in <= {3'h0, ~id};
		@(posedge clock);
	end
	endtask : send
endmodule : link_partner

// file: sim/tb_port_containment.sv
// Self-checking bench for the port containment block.
// Assumes an APB master on the core clock and the link_partner model.
module tb_port_containment;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [11:0] CTL = containment_pkg::OFS_CAP_CTRL;
	localparam logic [11:0] ST  = containment_pkg::OFS_STATUS;
	localparam logic [11:0] EV  = containment_pkg::OFS_EVT;
	localparam logic [11:0] MSK = containment_pkg::OFS_MASK;
	localparam logic [2:0]  K_UNC = 3'h4;
	localparam logic [2:0]  K_NF  = 3'h2;
	localparam logic [2:0]  K_FAT = 3'h1;

	logic                     clock, sys_rst, psel, penable, pwrite;
	logic                     pready, pslverr, contained, msi_req;
	logic                     err_cor_req, irq, err;
	logic [11:0]              paddr;
	logic [31:0]              pwdata, prdata, rd;
	logic [2:0]               cpl_status;
	logic [4:0]               msi_vector;
	containment_pkg::err_in_s err_in;
	int                       n_errors = 0, tests_run = 0;
	int                       n_msi = 0, n_cor = 0, cycles = 0;

	// Core clock, 5 ns period
	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	port_containment i_port_containment (
		.clock(clock), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.err_in(err_in), .contained(contained), .cpl_status(cpl_status),
		.msi_req(msi_req), .msi_vector(msi_vector),
		.err_cor_req(err_cor_req), .irq(irq)
	);

	link_partner i_link_partner (
		.clock(clock),
		.err_in(err_in)
	);

	// Count one-cycle pulses so that a missing or doubled one shows up
	always @(posedge clock)
	begin
		if (msi_req === 1'b1) n_msi++;
		if (err_cor_req === 1'b1) n_cor++;
		cycles++;
		if (cycles == 5000)
		begin
			n_errors++;
			give_verdict();
		end
	end

	task give_verdict;
	begin
		$display("checks=%0d mismatches=%0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	end
	endtask : give_verdict

	task check(input logic [31:0] seen, input logic [31:0] exp);
	begin
		tests_run++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	end
	endtask : check

	// One APB transfer; the request holds until the edge at which pready
	// is seen high, read data is taken there, and only then released
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
	begin
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1)
			@(posedge clock);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	end
	endtask : apb

	task rd_chk(input logic [11:0] a, input logic [31:0] exp);
	begin
		apb(1'b0, a, 32'h0000_0000);
		check(rd, exp);
		check({31'h0, err}, 32'h0000_0000);
	end
	endtask : rd_chk

	initial
	begin
		sys_rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		repeat (3) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		rd_chk(CTL, 32'h0000_0001);
		rd_chk(ST, 32'h0000_0000);
		check({29'h0, cpl_status}, 32'h0000_0004);
		check({27'h0, msi_vector}, 32'h0000_0001);
		// Reserved and disabled modes: no error kind may trigger
		apb(1'b1, CTL, 32'hFFFF_FFFF);
		rd_chk(CTL, 32'h001F_0001);
		check({29'h0, cpl_status}, 32'h0000_0001);
		for (int m = 0; m < 2; m++)
		begin
			for (int i = 0; i < 3; i++)
				i_link_partner.send(3'h1 << i, 16'h5A5A);
			rd_chk(ST, 32'h0000_0000);
			apb(1'b1, CTL, 32'h0000_0000);
		end
		// Fatal-only mode with interrupt and ERR_COR signalling
		apb(1'b1, MSK, 32'h0000_0001);
		apb(1'b1, EV, 32'h0000_000F);
		apb(1'b1, CTL, 32'h0019_0000);
		i_link_partner.send(K_NF, 16'h5555);
		rd_chk(ST, 32'h0000_0000);
		check({31'h0, irq}, 32'h0000_0000);
		i_link_partner.send(K_FAT, 16'h1234);
		check({31'h0, contained}, 32'h0000_0001);
		rd_chk(ST, 32'h1234_000D);
		check(32'(n_msi), 32'h0000_0001);
		check(32'(n_cor), 32'h0000_0001);
		check({31'h0, irq}, 32'h0000_0001);
		// A later trigger while contained must not disturb the capture
		i_link_partner.send(K_UNC, 16'h7777);
		rd_chk(ST, 32'h1234_000D);
		check(32'(n_msi), 32'h0000_0001);
		rd_chk(EV, 32'h0000_000F);
		apb(1'b1, MSK, 32'h0000_0000);
		check({31'h0, irq}, 32'h0000_0000);
		apb(1'b1, EV, 32'h0000_000F);
		rd_chk(EV, 32'h0000_0000);
		// Partial write-one-to-clear, then the rest
		apb(1'b1, ST, 32'h0000_0008);
		rd_chk(ST, 32'h1234_0005);
		apb(1'b1, ST, 32'h0000_0007);
		apb(1'b0, ST, 32'h0000_0000);
		check({28'h0, rd[3:0]}, 32'h0000_0000);
		check({31'h0, contained}, 32'h0000_0000);
		// Any-message mode, signalling off
		apb(1'b1, CTL, 32'h0002_0000);
		// Completion status is registered one cycle behind the control bit
		@(posedge clock);
		check({29'h0, cpl_status}, 32'h0000_0004);
		i_link_partner.send(K_NF, 16'hABCD);
		rd_chk(ST, 32'hABCD_0003);
		check(32'(n_msi), 32'h0000_0001);
		check(32'(n_cor), 32'h0000_0001);
		apb(1'b1, ST, 32'h0000_000F);
		// Local error in fatal-only mode; source ID stays as it was
		apb(1'b1, CTL, 32'h0001_0000);
		i_link_partner.send(K_UNC, 16'h2222);
		rd_chk(ST, 32'hABCD_0001);
		apb(1'b1, ST, 32'h0000_000F);
		apb(1'b1, CTL, 32'h0006_0000);
		@(posedge clock);
		check({29'h0, cpl_status}, 32'h0000_0001);
		i_link_partner.send(K_FAT, 16'h0F0F);
		rd_chk(ST, 32'h0F0F_0005);
		// Unmapped address: error response, read as zero
		apb(1'b0, 12'h300, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		check({31'h0, err}, 32'h0000_0001);
		// Unmapped write: error response and no register disturbed
		apb(1'b1, 12'h300, 32'hFFFF_FFFF);
		check({31'h0, err}, 32'h0000_0001);
		rd_chk(CTL, 32'h0006_0001);
		give_verdict();
	end
endmodule : tb_port_containment
